// ---- rtl/utdb_cfg.svh ----
`ifndef UTDB_CFG_SVH
`define UTDB_CFG_SVH
// Status bit positions
`define UTDB_ST_SHIFT_BIT  0
`define UTDB_ST_FULL_BIT   1
// Reset values
`define UTDB_STATUS_RST    8'h00
`define UTDB_LINE_IDLE     10'h3ff
// Frame and timing
`define UTDB_FRAME_BITS    10
`define UTDB_CLK_HZ        50000000
`define UTDB_BAUD_BPS      115200
`define UTDB_BIT_CYCLES    (`UTDB_CLK_HZ / `UTDB_BAUD_BPS)
`define UTDB_FIFO_DEPTH    16
`endif

// ---- rtl/utdb_pkg.sv ----
package utdb_pkg;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    UTDB_IDLE  = 2'b00,
    UTDB_LOAD  = 2'b01,
    UTDB_SHIFT = 2'b10
  } utdb_state_t;
endpackage : utdb_pkg

// ---- rtl/utdb_top.sv ----
`timescale 1ns/1ps
`include "utdb_cfg.svh"
// Summary of operation
// - Buffer writable once shifter starts shifting; in LIN mode only once status is all zero
// - Shifting flag sits at status bit 0
// - Buffer-full flag 0 writable, 1 not
// - Shifting flag 1 during frame, else 0
// - Flags step 10, 11, 01 back to back
// - Completion interrupt raised after every frame

// ----------------------------------------------------------------
// Synchronous FIFO
// ----------------------------------------------------------------
module utdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `UTDB_FIFO_DEPTH
) (
  input  wire logic             clock_in,   // System clock
  input  wire logic             rst_in,     // Sync reset, high
  input  wire logic [WIDTH-1:0] in_data_in, // Write data
  input  wire logic             in_valid_in, // Write valid
  output logic                  in_ready_out, // Not full
  output logic [WIDTH-1:0]      out_data_out, // Head word
  output logic                  out_valid_out, // Not empty
  input  wire logic             out_ready_in  // Drain strobe
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              push;
  wire              pop;
  wire              empty;
  wire              full;

  // Pointer compare with wrap bit
  assign empty         = (wr_ptr_r == rd_ptr_r);
  assign full          = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                         (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;
  assign out_data_out  = mem_r[rd_ptr_r[AW-1:0]];

  // Storage
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule : utdb_fifo

// ----------------------------------------------------------------
// Double-buffered transmitter
// ----------------------------------------------------------------
module utdb_top import utdb_pkg::*; #(
  parameter int BIT_CYCLES = `UTDB_BIT_CYCLES,
  parameter int FIFO_DEPTH = `UTDB_FIFO_DEPTH
) (
  input  wire logic       clock_in,            // 50 MHz clock
  input  wire logic       rst_in,              // Sync reset, high
  input  wire logic [7:0] data_in,             // Byte to send
  input  wire logic       data_valid_in,       // Byte offered
  output logic            data_ready_out,      // FIFO has room
  input  wire logic       lin_mode_in,         // Single-frame mode
  output logic            txd_out,             // Serial line
  output logic [7:0]      status_out,          // Transmit status
  output logic            tx_complete_irq_out  // Frame done pulse
);
  localparam logic [3:0]  LAST_BIT = 4'(`UTDB_FRAME_BITS - 1);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

  utdb_state_t state_r;
  utdb_state_t state_nxt;
  logic [7:0]  tx_holding_buffer_r;
  logic        tx_buffer_full_flag_r;
  logic        tx_buffer_full_flag_nxt;
  logic [9:0]  tx_shift_register_r;
  logic [3:0]  bit_cnt_r;
  logic [15:0] baud_cnt_r;
  logic        irq_r;
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  wire         tx_shifting_flag;
  wire         buf_ready;
  wire         buf_wr;
  wire         baud_tick;
  wire         frame_end;
  wire         in_load;

  // Input queue ahead of the holding buffer
  utdb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_data_in    (data_in),
    .in_valid_in   (data_valid_in),
    .in_ready_out  (data_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (buf_wr)
  );

  // Status and write permission decode
  assign tx_shifting_flag = (state_r != UTDB_IDLE);
  assign status_out = {6'h00, tx_buffer_full_flag_r, tx_shifting_flag};
  // Full blocks writes; LIN waits for all-zero status
  assign buf_ready = !tx_buffer_full_flag_r &&
                     (!lin_mode_in || status_out == `UTDB_STATUS_RST);
  assign buf_wr    = fifo_valid && buf_ready;
  assign in_load   = (state_r == UTDB_LOAD);
  assign baud_tick = (state_r == UTDB_SHIFT) && (baud_cnt_r == BIT_LAST);
  assign frame_end = baud_tick && (bit_cnt_r == LAST_BIT);
  assign txd_out   = tx_shift_register_r[0];
  assign tx_complete_irq_out = irq_r;

  // Full flag: set on write, cleared as shifter takes byte
  assign tx_buffer_full_flag_nxt = buf_wr ? 1'b1 :
                                   (in_load ? 1'b0 : tx_buffer_full_flag_r);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      UTDB_IDLE:  if (tx_buffer_full_flag_r) state_nxt = UTDB_LOAD;
      UTDB_LOAD:  state_nxt = UTDB_SHIFT;
      UTDB_SHIFT: if (frame_end) begin
        state_nxt = tx_buffer_full_flag_r ? UTDB_LOAD : UTDB_IDLE;
      end
      default:    state_nxt = UTDB_IDLE;
    endcase
  end

  // Buffer and state registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r               <= UTDB_IDLE;
      tx_buffer_full_flag_r <= 1'b0;
      tx_holding_buffer_r   <= 8'h00;
      irq_r                 <= 1'b0;
    end else begin
      state_r               <= state_nxt;
      tx_buffer_full_flag_r <= tx_buffer_full_flag_nxt;
      if (buf_wr) tx_holding_buffer_r <= fifo_data;
      irq_r                 <= frame_end;
    end
  end

  // Shifter, bit counter and baud divider
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_shift_register_r <= `UTDB_LINE_IDLE;
      bit_cnt_r           <= 4'h0;
      baud_cnt_r          <= 16'h0000;
    end else if (in_load) begin
      tx_shift_register_r <= {1'b1, tx_holding_buffer_r, 1'b0};
      bit_cnt_r           <= 4'h0;
      baud_cnt_r          <= 16'h0000;
    end else if (baud_tick) begin
      tx_shift_register_r <= {1'b1, tx_shift_register_r[9:1]};
      bit_cnt_r           <= bit_cnt_r + 4'h1;
      baud_cnt_r          <= 16'h0000;
    end else if (state_r == UTDB_SHIFT) begin
      baud_cnt_r          <= baud_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam logic [19:0] IRQ_AT = 20'(`UTDB_FRAME_BITS * BIT_CYCLES + 1);
  logic [19:0] irq_wait_r;

  // Cycles since the shifter last took a byte, for the frame-time check
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_wait_r <= 20'h00000;
    end else if (in_load) begin
      irq_wait_r <= 20'h00001;
    end else if (irq_r) begin
      irq_wait_r <= 20'h00000;
    end else if (irq_wait_r != 20'h00000) begin
      irq_wait_r <= irq_wait_r + 20'h00001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_write_when_empty: assert property (
    buf_wr |-> !tx_buffer_full_flag_r ##1 tx_buffer_full_flag_r)
    else $error("Holding buffer written while full");
  chk_full_holds_off: assert property (
    tx_buffer_full_flag_r && !in_load |=> tx_buffer_full_flag_r &&
      $stable(tx_holding_buffer_r))
    else $error("Full buffer lost its byte");
  chk_idle_takes_byte: assert property (
    state_r == UTDB_IDLE && tx_buffer_full_flag_r |=> in_load)
    else $error("Idle shifter ignored buffered byte");
  chk_flag_sequence: assert property (
    status_out[1:0] == 2'b10 && state_r == UTDB_IDLE |=>
      status_out[1:0] == 2'b11 ##1 status_out[1:0] == 2'b01)
    else $error("Flags did not step 10 11 01");
  chk_load_frees_buf: assert property (
    in_load |=> !tx_buffer_full_flag_r && state_r == UTDB_SHIFT && !txd_out)
    else $error("Shifter start did not free buffer");
  chk_irq_per_frame: assert property (
    irq_wait_r <= IRQ_AT && (irq_r == (irq_wait_r == IRQ_AT)))
    else $error("Frame finished without completion pulse");
  chk_shift_clears: assert property (
    frame_end && !tx_buffer_full_flag_r |=> status_out[`UTDB_ST_SHIFT_BIT] == 1'b0)
    else $error("Shifting flag stuck after frame");
  chk_shift_bit0: assert property (
    $rose(status_out[0]) |-> $past(tx_buffer_full_flag_r) && in_load)
    else $error("Shifting flag rose without a load");
  chk_lin_single: assert property (
    lin_mode_in && status_out != 8'h00 |-> !buf_wr)
    else $error("LIN mode queued a second byte");
  chk_status_high_zero: assert property (
    status_out[7:2] == 6'h00)
    else $error("Reserved status bits set");

  cov_back_to_back: cover property (frame_end && tx_buffer_full_flag_r);
  cov_lin_frame:    cover property (lin_mode_in && buf_wr);
  cov_fifo_full:    cover property (data_valid_in && !data_ready_out);
  cov_frame_done:   cover property (irq_r ##1 !status_out[0]);
endmodule : utdb_top

// ---- tb/utdb_rx_model.sv ----
`timescale 1ns/1ps
// --------------------------------------
// Remote serial receiver model
// --------------------------------------
module utdb_rx_model #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic clock_in, // System clock
  input  wire logic line_in   // Serial line
);
  logic [7:0] got[$];
  int         frame_errs = 0;
  // Sample each bit in mid period, LSB first
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(negedge line_in);
      repeat (BIT_CYCLES / 2) @(posedge clock_in);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge clock_in);
        if (i < 8) b[i] = line_in;
        else if (line_in !== 1'b1) frame_errs++;
      end
      got.push_back(b);
    end
  end
endmodule : utdb_rx_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
  localparam int BITS = 4;
  logic       clock_in = 0, rst_in = 1, data_valid_in = 0, lin_mode_in = 0;
  logic [7:0] data_in = 8'h00;
  wire logic  data_ready_out, txd_out, tx_complete_irq_out;
  wire logic [7:0] status_out;
  int         mismatches = 0, total_checks = 0, irqs = 0, full_seen = 0;
  logic [7:0] sent[$];
  logic [1:0] prev = 2'b00;
  always #10 clock_in = ~clock_in;
  utdb_top #(.BIT_CYCLES(BITS), .FIFO_DEPTH(16)) i_dut (.clock_in(clock_in), .rst_in(rst_in),
    .data_in(data_in), .data_valid_in(data_valid_in), .data_ready_out(data_ready_out),
    .lin_mode_in(lin_mode_in), .txd_out(txd_out), .status_out(status_out),
    .tx_complete_irq_out(tx_complete_irq_out));
  utdb_rx_model #(.BIT_CYCLES(BITS)) i_rx (.clock_in(clock_in), .line_in(txd_out));
  // ----------------------------------
  // Flag sequence expectation
  // ----------------------------------
  function automatic logic [1:0] next_flags(input logic [1:0] p);
    return (p == 2'b10) ? 2'b11 : 2'b01;
  endfunction : next_flags
  // Watch flags, line and handshake every rising edge
  always @(posedge clock_in) if (!rst_in) begin
    if (tx_complete_irq_out) irqs++;
    if (data_valid_in && data_ready_out) sent.push_back(data_in);
    if (!data_ready_out) full_seen++;
    `CHK(status_out[7:2], 6'h00, "status spare bits")
    if (txd_out === 1'b0) `CHK(status_out[0], 1'b1, "line busy, flag low")
    if (prev == 2'b10) `CHK(status_out[1:0], next_flags(prev), "after 10")
    if (prev == 2'b11 && status_out[1:0] !== prev)
      `CHK(status_out[1:0], next_flags(prev), "after 11")
    if (lin_mode_in && !prev[1] && status_out[1]) `CHK(prev, 2'b00, "lin refill")
    prev <= status_out[1:0];
  end
  // ----------------------------------
  // Stimulus and checking tasks
  // ----------------------------------
  task automatic send(input int n, input bit corner);
    for (int k = 0; k < n; k++) begin
      data_in = corner ? 8'h00 ^ {8{k[0]}} : 8'($urandom);
      data_valid_in = 1'b1;
      while (data_ready_out !== 1'b1) @(negedge clock_in);
      @(negedge clock_in);
    end
    data_valid_in = 1'b0;
  endtask : send
  task automatic finish_test(input string name);
    for (int t = 0; t < 4000 && !(status_out === 8'h00 && i_rx.got.size() == sent.size()); t++)
      @(negedge clock_in);
    repeat (BITS * 3) @(negedge clock_in);
    `CHK(i_rx.got.size(), sent.size(), "frame count")
    for (int k = 0; k < sent.size() && k < i_rx.got.size(); k++)
      `CHK(i_rx.got[k], sent[k], "byte order")
    `CHK(i_rx.frame_errs, 0, "stop bit")
    `CHK(irqs, sent.size(), "irq per frame")
    `CHK(status_out, 8'h00, "idle status")
    $display("test %s done", name);
    sent.delete();
    i_rx.got.delete();
    irqs = 0;
  endtask : finish_test
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // ----------------------------------
  // Main sequence and watchdog
  // ----------------------------------
  initial begin
    void'($urandom(32'hceb6));
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    `CHK({txd_out, data_ready_out, status_out}, 10'h300, "reset state")
    send(1, 1'b1);
    finish_test("single");
    send(6, 1'b1);
    finish_test("corner back to back");
    send(22, 1'b0);
    `CHK(full_seen > 0, 1'b1, "fifo refusal")
    finish_test("random burst");
    lin_mode_in = 1'b1;
    send(4, 1'b0);
    finish_test("lin mode");
    // Reinit only once the last frame has drained
    lin_mode_in = 1'b0;
    `CHK(status_out, 8'h00, "idle before reinit")
    rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    `CHK({txd_out, data_ready_out, status_out}, 10'h300, "reinit state")
    send(3, 1'b0);
    finish_test("after reinit");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    mismatches++;
    close_out();
  end
endmodule : testbench
